// ### include/aenp_consts.vh
// Constants for the expansion status and next-page transmit registers
// How it works
// - Reserved bits of both registers always read back as zero.
// - Override-write bits accept writes only while the override bit is one.
// - Parallel detection fault sets and latches the fault status bit.
// - Partner next-page-able follows the next-page bit of received words.
// - Local next-page-able status always reads one.
// - Each stored received word sets and latches page-received.
// - Reading the expansion register clears page-received.
// - Partner negotiation-able is one only while valid bursts arrive.
// - Outgoing next-page bit follows the writable more-pages flag.
// - Next pages go out only if flag set and partner is able.
// - Outgoing message-page bit copies the message format flag.
// - Outgoing acknowledge-2 bit copies the comply ability flag.
// - The code field is copied into the outgoing next-page word.
// - Toggle inverts per next page, starting from inverted base bit 11.
`ifndef AENP_CONSTS_VH
`define AENP_CONSTS_VH

`define AENP_REG_EXP     5'h06
`define AENP_REG_NPTX    5'h07
`define AENP_NPTX_RST    16'h2001
`define AENP_NPTX_WMASK  16'hb7ff
`define AENP_CW_RST      11'h000
`define AENP_CW_LSB      5
`define AENP_CW_MSB      15
`define AENP_CW_W        11

`define AENP_B_PDF       4
`define AENP_B_LPNP      3
`define AENP_B_NPA       2
`define AENP_B_PR        1
`define AENP_B_LPAN      0
`define AENP_B_NP        15
`define AENP_B_MP        13
`define AENP_B_COMPLY_ABILITY_FLAG      12
`define AENP_B_TGL       11
`define AENP_CODE_MSB    10

`define AENP_LH_PDF      0
`define AENP_LH_PR       1
`define AENP_LH_N        2

`define AENP_PRE_LEN     6'h20
`define AENP_OP_LEN      5'h02
`define AENP_ADR_LEN     5'h0a
`define AENP_TA_LEN      5'h02
`define AENP_DAT_LEN     5'h10
`define AENP_OP_RD       2'h2
`define AENP_OP_WR       2'h1

`endif

// ### core/aenp_sync.v
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module aenp_sync #(
	parameter W = 2
) (
	input  wire         clk_sys, // System clock
	input  wire         rst_n,   // Async reset, active low
	input  wire [W-1:0] d_async, // Pin levels
	output reg  [W-1:0] q_sync   // Synchronised levels
);
	reg [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= {W{1'b0}};
			q_sync   <= {W{1'b0}};
		end
		else
		begin
			meta_reg <= d_async;
			q_sync   <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ### core/aenp_lhbit.v
// Latching-high status bits with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
`include "aenp_consts.vh"
module aenp_lhbit #(
	parameter N = 2
) (
	input  wire         clk_sys, // System clock
	input  wire         rst_n,   // Async reset, active low
	input  wire [N-1:0] set_evt, // Event pulses
	input  wire         rd_clr,  // Register read pulse
	output reg  [N-1:0] q        // Latched status
);
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1)
		begin : g_bit
			// An event in the read cycle survives the clear
			always @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
					q[i] <= 1'b0;
				else
					q[i] <= set_evt[i] | (q[i] & ~rd_clr);
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### core/aenp_regs.v
// Expansion status and next-page transmit registers behind serial management
`timescale 1ns/1ps
`default_nettype none
`include "aenp_consts.vh"
module aenp_regs #(
	parameter [4:0] PHY_ADDR = 5'h01
) (
	input  wire        clk_sys,     // System clock, 40 MHz
	input  wire        rst_n,       // Async reset, active low
	input  wire        mdc,         // Management clock pin
	input  wire        mdio_in,     // Management data pin, input side
	output reg         mdio_out,    // Management data pin, output side
	output reg         mdio_oe_n,   // Low while driving management data
	input  wire        override_en, // Command override enable
	input  wire        pd_fault,    // Parallel detection fault pulse
	input  wire        page_stored, // Received word stored pulse
	input  wire        rx_np_bit,   // Next-page bit of received word
	input  wire        flp_valid,   // Valid partner bursts seen, level
	input  wire        base_sent,   // Base word sent pulse
	input  wire        base_bit11,  // Bit 11 of the base word
	input  wire        np_sent,     // Next-page word sent pulse
	output reg  [15:0] np_word,     // Next-page word for the link
	output reg         np_send_en,  // Next pages to follow base word
	output reg  [10:0] aux_cw       // Override-write bits for aux use
);
	localparam [2:0] S_PRE = 3'h0;
	localparam [2:0] S_ST  = 3'h1;
	localparam [2:0] S_OP  = 3'h2;
	localparam [2:0] S_ADR = 3'h3;
	localparam [2:0] S_TA  = 3'h4;
	localparam [2:0] S_DAT = 3'h5;

	wire [1:0]           pin_s;
	wire                 mdc_s;
	wire                 mdio_s;
	wire [`AENP_LH_N-1:0] lh_q;
	wire [`AENP_LH_N-1:0] lh_set;
	wire                 mdc_rise;
	wire                 adr_hit;
	wire [4:0]           adr_reg_f;
	wire [4:0]           adr_phy_f;

	reg        mdc_d_reg;
	reg [2:0]  state_reg;
	reg [5:0]  pre_cnt_reg;
	reg [4:0]  cnt_reg;
	reg [1:0]  op_reg;
	reg [9:0]  adr_reg;
	reg [15:0] shf_reg;
	reg        rd_act_reg;
	reg        exp_rd_reg;
	reg [15:0] nptx_reg;
	reg        toggle_reg;
	reg        lp_np_reg;
	reg        lp_an_reg;

	aenp_sync #(
		.W (2)
	) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d_async ({mdc, mdio_in}),
		.q_sync  (pin_s)
	);

	assign mdc_s  = pin_s[1];
	assign mdio_s = pin_s[0];

	assign lh_set[`AENP_LH_PDF] = pd_fault;
	assign lh_set[`AENP_LH_PR]  = page_stored;

	aenp_lhbit #(
		.N (`AENP_LH_N)
	) u_lh (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.set_evt (lh_set),
		.rd_clr  (exp_rd_reg),
		.q       (lh_q)
	);

	assign mdc_rise  = mdc_s & ~mdc_d_reg;
	assign adr_phy_f = adr_reg[9:5];
	assign adr_reg_f = adr_reg[4:0];
	assign adr_hit   = (adr_phy_f == PHY_ADDR);

	// Read view of the two registers; other addresses read zero
	function [15:0] rd_mux;
		input [4:0]  ra;
		input [15:0] nptx;
		input        tgl;
		input [1:0]  lh;
		input        lpnp;
		input        lpan;
		begin
			rd_mux = 16'h0000;
			if (ra == `AENP_REG_EXP)
			begin
				rd_mux[`AENP_B_PDF]  = lh[`AENP_LH_PDF];
				rd_mux[`AENP_B_LPNP] = lpnp;
				rd_mux[`AENP_B_NPA]  = 1'b1;
				rd_mux[`AENP_B_PR]   = lh[`AENP_LH_PR];
				rd_mux[`AENP_B_LPAN] = lpan;
			end
			else if (ra == `AENP_REG_NPTX)
			begin
				rd_mux = nptx & `AENP_NPTX_WMASK;
				rd_mux[`AENP_B_TGL] = tgl;
			end
		end
	endfunction

	// Serial management frame receiver and read-data driver
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mdc_d_reg   <= 1'b0;
			state_reg   <= S_PRE;
			pre_cnt_reg <= 6'h00;
			cnt_reg     <= 5'h00;
			op_reg      <= 2'h0;
			adr_reg     <= 10'h000;
			shf_reg     <= 16'h0000;
			rd_act_reg  <= 1'b0;
			exp_rd_reg  <= 1'b0;
			mdio_out    <= 1'b0;
			mdio_oe_n   <= 1'b1;
			nptx_reg    <= `AENP_NPTX_RST;
			aux_cw      <= `AENP_CW_RST;
		end
		else
		begin
			mdc_d_reg  <= mdc_s;
			exp_rd_reg <= 1'b0;
			if (mdc_rise)
			begin
				case (state_reg)
				S_PRE:
				begin
					if (mdio_s)
					begin
						if (pre_cnt_reg != `AENP_PRE_LEN)
							pre_cnt_reg <= pre_cnt_reg + 6'h01;
					end
					else
					begin
						// A zero after a full preamble is the start's first bit
						if (pre_cnt_reg == `AENP_PRE_LEN)
							state_reg <= S_ST;
						pre_cnt_reg <= 6'h00;
					end
				end
				S_ST:
				begin
					cnt_reg   <= 5'h00;
					state_reg <= mdio_s ? S_OP : S_PRE;
				end
				S_OP:
				begin
					op_reg  <= {op_reg[0], mdio_s};
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == `AENP_OP_LEN - 5'h01)
					begin
						cnt_reg   <= 5'h00;
						state_reg <= S_ADR;
					end
				end
				S_ADR:
				begin
					adr_reg <= {adr_reg[8:0], mdio_s};
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == `AENP_ADR_LEN - 5'h01)
					begin
						cnt_reg   <= 5'h00;
						state_reg <= S_TA;
					end
				end
				S_TA:
				begin
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == 5'h00)
					begin
						// Snapshot taken before the clear takes effect
						if (op_reg == `AENP_OP_RD && adr_hit)
						begin
							shf_reg <= rd_mux(adr_reg_f, nptx_reg,
								toggle_reg, lh_q, lp_np_reg, lp_an_reg);
							rd_act_reg <= 1'b1;
							mdio_out   <= 1'b0;
							mdio_oe_n  <= 1'b0;
							if (adr_reg_f == `AENP_REG_EXP)
								exp_rd_reg <= 1'b1;
						end
					end
					else
					begin
						cnt_reg   <= 5'h00;
						state_reg <= S_DAT;
						if (rd_act_reg)
						begin
							mdio_out <= shf_reg[15];
							shf_reg  <= {shf_reg[14:0], 1'b0};
						end
					end
				end
				S_DAT:
				begin
					cnt_reg <= cnt_reg + 5'h01;
					if (rd_act_reg)
					begin
						mdio_out <= shf_reg[15];
						shf_reg  <= {shf_reg[14:0], 1'b0};
					end
					else
						shf_reg <= {shf_reg[14:0], mdio_s};
					if (cnt_reg == `AENP_DAT_LEN - 5'h01)
					begin
						state_reg   <= S_PRE;
						pre_cnt_reg <= 6'h00;
						rd_act_reg  <= 1'b0;
						mdio_oe_n   <= 1'b1;
						mdio_out    <= 1'b0;
						if (op_reg == `AENP_OP_WR && adr_hit)
						begin
							// Reserved and read-only bits never store
							if (adr_reg_f == `AENP_REG_NPTX)
								nptx_reg <= {shf_reg[14:0], mdio_s}
									& `AENP_NPTX_WMASK;
							if (adr_reg_f == `AENP_REG_EXP && override_en)
								aux_cw <= shf_reg[`AENP_CW_MSB-1:
									`AENP_CW_LSB-1];
						end
					end
				end
				default:
				begin
					state_reg   <= S_PRE;
					pre_cnt_reg <= 6'h00;
				end
				endcase
			end
		end
	end

	// Partner status and outgoing next-page word
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lp_np_reg  <= 1'b0;
			lp_an_reg  <= 1'b0;
			toggle_reg <= 1'b0;
			np_word    <= 16'h0000;
			np_send_en <= 1'b0;
		end
		else
		begin
			if (page_stored)
				lp_np_reg <= rx_np_bit;
			lp_an_reg  <= flp_valid;
			np_send_en <= nptx_reg[`AENP_B_NP] & lp_np_reg;
			if (base_sent)
				toggle_reg <= ~base_bit11;
			else if (np_sent)
			begin
				toggle_reg <= ~toggle_reg;
				np_word <= 16'h0000;
				np_word[`AENP_B_NP]   <= nptx_reg[`AENP_B_NP];
				np_word[`AENP_B_MP]   <= nptx_reg[`AENP_B_MP];
				np_word[`AENP_B_COMPLY_ABILITY_FLAG] <= nptx_reg[`AENP_B_COMPLY_ABILITY_FLAG];
				np_word[`AENP_B_TGL]  <= toggle_reg;
				np_word[`AENP_CODE_MSB:0] <=
					nptx_reg[`AENP_CODE_MSB:0];
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/aenp_monitor.sv
// Assertion checker for the expansion and next-page registers
`timescale 1ns/1ps
`default_nettype none
module aenp_monitor (
	input wire logic        clk_sys,     // Clock
	input wire logic        rst_n,       // Reset
	input wire logic        mdio_out,    // Pin data
	input wire logic        mdio_oe_n,   // Pin enable
	input wire logic        override_en, // Override bit
	input wire logic        page_stored, // Word stored
	input wire logic        rx_np_bit,   // Partner np bit
	input wire logic        base_sent,   // Base sent
	input wire logic        base_bit11,  // Base bit 11
	input wire logic        np_sent,     // Page sent
	input wire logic [15:0] np_word,     // Page word
	input wire logic        np_send_en,  // Send gate
	input wire logic [10:0] aux_cw       // Override bits
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic tgl_reg;
	// Expected toggle, seeded by each base word
	always @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			tgl_reg <= 1'b0;
		else if (base_sent)
			tgl_reg <= ~base_bit11;
		else if (np_sent)
			tgl_reg <= ~tgl_reg;
	a_word_rsv: assert property (np_word[14] == 1'b0)
		else $error("np_word bit 14 set");
	a_cw_locked: assert property (!override_en [*2] |=> $stable(aux_cw))
		else $error("aux_cw changed while locked");
	a_tgl_seq: assert property (np_sent |=> np_word[11] == $past(tgl_reg))
		else $error("toggle bit wrong");
	a_word_hold: assert property (!np_sent |=> $stable(np_word))
		else $error("np_word moved without a send");
	a_send_gate: assert property ((page_stored && !rx_np_bit) ##1
		!page_stored [*2] |-> !np_send_en)
		else $error("send gate open without partner");
	a_idle_low: assert property (mdio_oe_n |-> !mdio_out)
		else $error("data while released");
	a_ta_low: assert property ($fell(mdio_oe_n) |-> !mdio_out)
		else $error("turnaround bit not zero");
	a_drive_len: assert property ($fell(mdio_oe_n) |=> !mdio_oe_n [*8])
		else $error("read drive too short");
	cover property (np_sent);
	cover property ($fell(mdio_oe_n));
	cover property (override_en && $changed(aux_cw));
endmodule
`default_nettype wire

// ### testbench/aenp_sta.sv
// Management station model driving serial frames
`timescale 1ns/1ps
`default_nettype none
module aenp_sta (
	input  wire logic clk_sys,   // Clock
	input  wire logic mdio_out,  // Device data
	input  wire logic mdio_oe_n, // Device enable
	output var  logic mdc,       // Management clock
	output wire logic mdio_line  // Pin level
);
	logic drv = 1'b1;
	logic en = 1'b0;
	initial mdc = 1'b0;
	// Pull-up: a released line reads one
	assign mdio_line = (en ? drv : 1'b1) & (mdio_oe_n | mdio_out);
	task automatic bitx(input logic b, input logic e, output logic s);
		@(posedge clk_sys) #1;
		mdc = 1'b0;
		drv = b;
		en = e;
		repeat (9) @(posedge clk_sys);
		#1 mdc = 1'b1;
		s = mdio_line;
		repeat (9) @(posedge clk_sys);
	endtask
	task automatic xfer(input logic [4:0] pa, input logic [1:0] op,
		input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hd;
		logic s;
		logic w;
		hd = {32'hffffffff, 2'h1, op, pa, ra};
		w = (op == 2'h1);
		for (int i = 45; i >= 0; i--)
			bitx(hd[i], 1'b1, s);
		bitx(1'b1, w, s);
		bitx(1'b0, w, s);
		for (int i = 15; i >= 0; i--)
		begin
			bitx(wd[i], w, s);
			rd[i] = s;
		end
		@(posedge clk_sys) #1;
		en = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### testbench/aenp_regs_tb.sv
// Testbench for the expansion and next-page register block
`timescale 1ns/1ps
`default_nettype none
module aenp_regs_tb;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        override_en = 1'b0;
	logic        pd_fault = 1'b0;
	logic        page_stored = 1'b0;
	logic        rx_np_bit = 1'b0;
	logic        flp_valid = 1'b0;
	logic        base_sent = 1'b0;
	logic        base_bit11 = 1'b0;
	logic        np_sent = 1'b0;
	wire         mdc;
	wire         mdio_line;
	wire         mdio_out;
	wire         mdio_oe_n;
	wire  [15:0] np_word;
	wire         np_send_en;
	wire  [10:0] aux_cw;
	logic [15:0] rdat;
	int          fails = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	aenp_regs #(.PHY_ADDR(5'h01)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n), .override_en(override_en), .pd_fault(pd_fault),
		.page_stored(page_stored), .rx_np_bit(rx_np_bit),
		.flp_valid(flp_valid), .base_sent(base_sent), .base_bit11(base_bit11),
		.np_sent(np_sent), .np_word(np_word), .np_send_en(np_send_en),
		.aux_cw(aux_cw));
	aenp_sta i_sta (.clk_sys(clk_sys), .mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_line(mdio_line));
	always #12.5 clk_sys = ~clk_sys;
	task automatic close_out();
		$display("Compared %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Fourteen frames of 64 bits at 19 cycles each fit well inside this
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			fails = fails + 1;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
		i_sta.xfer(5'h01, 2'h2, ra, 16'h0000, rdat);
		chk("read", exp, rdat);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		i_sta.xfer(5'h01, 2'h1, ra, d, rdat);
	endtask
	task automatic pulse(ref logic p);
		@(posedge clk_sys) #1;
		p = 1'b1;
		@(posedge clk_sys) #1;
		p = 1'b0;
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		rd(5'h06, 16'h0004);
		rd(5'h07, 16'h2001);
		rd(5'h1f, 16'h0000);
		wr(5'h06, 16'hffe0);
		chk("aux_cw", 16'h0000, {5'h00, aux_cw});
		override_en = 1'b1;
		wr(5'h06, 16'hffe0);
		chk("aux_cw", 16'h07ff, {5'h00, aux_cw});
		override_en = 1'b0;
		rd(5'h06, 16'h0004);
		pulse(pd_fault);
		rx_np_bit = 1'b1;
		pulse(page_stored);
		flp_valid = 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(5'h06, 16'h001f);
		rd(5'h06, 16'h000d);
		wr(5'h07, 16'h9d55);
		rd(5'h07, 16'h9555);
		chk("np_send_en", 16'h0001, {15'h0000, np_send_en});
		base_bit11 = 1'b1;
		pulse(base_sent);
		pulse(np_sent);
		chk("np_word", 16'h9555, np_word);
		rd(5'h07, 16'h9d55);
		wr(5'h07, 16'h2123);
		chk("np_send_en", 16'h0000, {15'h0000, np_send_en});
		pulse(np_sent);
		chk("np_word", 16'h2923, np_word);
		wr(5'h07, 16'h8000);
		rx_np_bit = 1'b0;
		pulse(page_stored);
		repeat (3) @(posedge clk_sys);
		chk("np_send_en", 16'h0000, {15'h0000, np_send_en});
		base_bit11 = 1'b0;
		pulse(base_sent);
		pulse(np_sent);
		chk("np_word", 16'h8800, np_word);
		i_sta.xfer(5'h02, 2'h2, 5'h06, 16'h0000, rdat);
		chk("foreign read", 16'hffff, rdat);
		close_out();
	end
endmodule
bind aenp_regs aenp_monitor i_mon (.clk_sys(clk_sys), .rst_n(rst_n),
	.mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .override_en(override_en),
	.page_stored(page_stored), .rx_np_bit(rx_np_bit), .base_sent(base_sent),
	.base_bit11(base_bit11), .np_sent(np_sent), .np_word(np_word),
	.np_send_en(np_send_en), .aux_cw(aux_cw));
`default_nettype wire
